// ==== hdl/cpu_pkg.sv ====
package cpu_pkg;
  localparam logic [15:0] RESET_VEC  = 16'hfffe;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [15:0] STEP_WORD  = 16'h0002;
  localparam logic [15:0] STEP_BYTE  = 16'h0001;
  localparam logic [15:0] BYTE_MASK  = 16'h00ff;
  localparam logic [15:0] WORD_MASK  = 16'hffff;
  localparam int          MSB_BYTE   = 7;
  localparam int          MSB_WORD   = 15;
  // constant generator values
  localparam logic [15:0] CG_ZERO    = 16'h0000;
  localparam logic [15:0] CG_ONE     = 16'h0001;
  localparam logic [15:0] CG_TWO     = 16'h0002;
  localparam logic [15:0] CG_FOUR    = 16'h0004;
  localparam logic [15:0] CG_EIGHT   = 16'h0008;
  localparam logic [15:0] CG_ONES    = 16'hffff;
  // status register bit positions
  localparam int SR_C = 0, SR_Z = 1, SR_N = 2, SR_GIE = 3, SR_CPUOFF = 4;
  localparam int SR_OSCOFF = 5, SR_SCG0 = 6, SR_SCG1 = 7, SR_V = 8;
  // dedicated registers
  localparam logic [3:0] R_PC = 4'h0, R_SP = 4'h1, R_SR = 4'h2, R_CG = 4'h3;
  // instruction formats and opcodes
  localparam logic [2:0] FMT_JUMP   = 3'h1;
  localparam logic [5:0] FMT_SINGLE = 6'h04;
  localparam logic [2:0] OP_RRC = 3'h0, OP_SWPB = 3'h1, OP_RRA = 3'h2, OP_SXT = 3'h3;
  localparam logic [2:0] OP_PUSH = 3'h4, OP_CALL = 3'h5, OP_RETI = 3'h6;
  localparam logic [3:0] OP_MOV = 4'h4, OP_ADD = 4'h5, OP_ADDC = 4'h6, OP_SUBC = 4'h7;
  localparam logic [3:0] OP_SUB = 4'h8, OP_CMP = 4'h9, OP_DADD = 4'ha, OP_BIT = 4'hb;
  localparam logic [3:0] OP_BIC = 4'hc, OP_BIS = 4'hd, OP_XOR = 4'he, OP_AND = 4'hf;
  // source addressing field
  localparam logic [1:0] AM_REG = 2'h0, AM_IDX = 2'h1, AM_IND = 2'h2, AM_INC = 2'h3;
  // jump conditions
  localparam logic [2:0] JC_NE = 3'h0, JC_EQ = 3'h1, JC_NC = 3'h2, JC_C = 3'h3;
  localparam logic [2:0] JC_N = 3'h4, JC_GE = 3'h5, JC_L = 3'h6, JC_ALWAYS = 3'h7;

  typedef enum logic [3:0] {
    S_BOOT, S_FETCH, S_DECODE, S_SRCEXT, S_SRCRD, S_DSTEXT, S_DSTRD, S_EXEC,
    S_WRBACK, S_POPSR, S_POPPC, S_IRQPC, S_IRQSR, S_IRQVEC, S_SLEEP
  } cpu_state_e;

  typedef enum logic [2:0] {
    MODE_ACTIVE_OPERATING, MODE_LOW_POWER_ZERO, MODE_LOW_POWER_ONE,
    MODE_LOW_POWER_TWO, MODE_LOW_POWER_THREE, MODE_LOW_POWER_FOUR
  } power_mode_e;
endpackage

// ==== hdl/risc_cpu_core.sv ====
`timescale 1ns/1ns
// Functional notes
// RULE_01 - Sixteen registers: 0 program counter, 1 stack pointer, 2 status, 3 constants, 4-15 free.
// RULE_02 - A register-to-register operation executes in one clock cycle; here fetch, decode and execute take at least four cycles.
// RULE_03 - Operations act on registers with seven source and four destination addressing modes.
// RULE_04 - Three encoding formats carry the instruction set, each on word or byte operands; jumps here have no byte form.
// RULE_05 - Two-operand instructions combine source and destination and write the destination.
// RULE_06 - A call pushes the program counter and then loads the operand into it; here the operand is loaded in S_EXEC, before S_WRBACK writes the push.
// RULE_07 - Jumps are conditional or not; jump_if_not_equal branches only while zero flag is 0.
// RULE_08 - Peripherals and memory are reached alike over the shared data, address, control bus.
// RULE_09 - One active mode and five software-selected low-power modes exist.
// RULE_10 - Any interrupt wakes the core, runs the handler and returns to the earlier mode; here only while the GIE bit is set.
// RULE_11 - Mode zero halts the CPU and main clock; auxiliary and subsystem clocks run.
// RULE_12 - Mode one is mode zero plus dc generator off when the oscillator is unused.
// RULE_13 - Mode two stops CPU, main and subsystem clocks; dc generator and aux clock run.
// RULE_14 - Mode three stops CPU, main and subsystem clocks and dc generator; aux clock runs.
// RULE_15 - Mode four stops all clocks, the dc generator and the crystal oscillator; here subsystem clock also needs SCG1, dc generator SCG0.
// RULE_16 - Mode bits live in the status register, cleared on interrupt entry, restored on return.
module risc_cpu_core (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clkEn,
  input  wire logic [15:0]          busRdData,
  input  wire logic                 busAck,
  input  wire logic                 irqReq,
  input  wire logic [15:0]          irqVecAddr,
  input  wire logic                 oscInUseActive,
  output logic      [15:0]          busAddr,
  output logic      [15:0]          busWrData,
  output logic                      busRd,
  output logic                      busWr,
  output logic                      busByte,
  output logic                      irqAck,
  output logic                      mainClkEn,
  output logic                      subsystemClkEn,
  output logic                      auxClkEn,
  output logic                      dcGenEn,
  output logic                      xtalEn,
  output cpu_pkg::power_mode_e      powerMode
);
  cpu_pkg::cpu_state_e  state_reg, state_next;
  logic [15:0]          rf_reg [16];  // [RULE_01]
  logic [15:0]          rf_next [16];
  logic [15:0]          ir_reg, ir_next, srcVal_reg, srcVal_next, dstVal_reg, dstVal_next;
  logic [15:0]          srcAddr_reg, srcAddr_next, dstAddr_reg, dstAddr_next;
  logic [15:0]          busAddr_next, busWrData_next;
  logic                 busRd_next, busWr_next, busByte_next, irqAck_next;
  logic                 mainClkEn_next, subsystemClkEn_next, auxClkEn_next, dcGenEn_next;
  logic                 xtalEn_next;
  cpu_pkg::power_mode_e powerMode_next;
  logic [15:0]          sr, mask, opS, opD, addend, aluRes, jumpOff, incStep;
  logic [16:0]          sum;
  logic                 isJump, isSingle, isStack, bw, ad, cgHit, srcExt, sub, cin;
  logic                 aluC, aluV, aluFlags, busIdle, busDone;
  logic [3:0]           sReg, dReg, dop;
  logic [2:0]           sop;
  logic [1:0]           as;
  int                   msb;

  function automatic logic [15:0] cgValue(input logic [3:0] r, input logic [1:0] m);
    if (r == cpu_pkg::R_SR) return m[0] ? cpu_pkg::CG_EIGHT : cpu_pkg::CG_FOUR;
    case (m)
      cpu_pkg::AM_REG: return cpu_pkg::CG_ZERO;
      cpu_pkg::AM_IDX: return cpu_pkg::CG_ONE;
      cpu_pkg::AM_IND: return cpu_pkg::CG_TWO;
      default:         return cpu_pkg::CG_ONES;
    endcase
  endfunction

  // base for indexed, symbolic (pc) and absolute (status reg slot) forms
  function automatic logic [15:0] extBase(input logic [3:0] r, input logic [15:0] v);
    return (r == cpu_pkg::R_SR) ? cpu_pkg::ZERO16 : v;
  endfunction

  function automatic logic jumpTaken(input logic [2:0] c, input logic [15:0] s);
    case (c)
      cpu_pkg::JC_NE: return !s[cpu_pkg::SR_Z];  // [RULE_07]
      cpu_pkg::JC_EQ: return s[cpu_pkg::SR_Z];
      cpu_pkg::JC_NC: return !s[cpu_pkg::SR_C];
      cpu_pkg::JC_C:  return s[cpu_pkg::SR_C];
      cpu_pkg::JC_N:  return s[cpu_pkg::SR_N];
      cpu_pkg::JC_GE: return !(s[cpu_pkg::SR_N] ^ s[cpu_pkg::SR_V]);
      cpu_pkg::JC_L:  return s[cpu_pkg::SR_N] ^ s[cpu_pkg::SR_V];
      default:        return 1'b1;
    endcase
  endfunction

  // three formats, word or byte on the single- and double-operand ones, none on jumps [RULE_04]
  assign sr       = rf_reg[cpu_pkg::R_SR];
  assign isJump   = ir_reg[15:13] == cpu_pkg::FMT_JUMP;
  assign isSingle = ir_reg[15:10] == cpu_pkg::FMT_SINGLE;
  assign sop      = ir_reg[9:7];
  assign dop      = ir_reg[15:12];
  assign isStack  = isSingle && (sop == cpu_pkg::OP_PUSH || sop == cpu_pkg::OP_CALL);
  assign sReg     = isSingle ? ir_reg[3:0] : ir_reg[11:8];
  assign dReg     = ir_reg[3:0];
  assign as       = ir_reg[5:4];
  assign bw       = ir_reg[6];
  assign ad       = ir_reg[7] && !isSingle;
  assign cgHit    = sReg == cpu_pkg::R_CG || (sReg == cpu_pkg::R_SR && as[1]);  // [RULE_01]
  assign srcExt   = as == cpu_pkg::AM_IDX || (as == cpu_pkg::AM_INC && sReg == cpu_pkg::R_PC);
  assign jumpOff  = {{5{ir_reg[9]}}, ir_reg[9:0], 1'b0};
  assign incStep  = (bw && sReg != cpu_pkg::R_SP) ? cpu_pkg::STEP_BYTE : cpu_pkg::STEP_WORD;
  assign busIdle  = !busRd && !busWr;
  assign busDone  = busAck && !busIdle;

  // operand unit
  always_comb begin
    msb      = bw ? cpu_pkg::MSB_BYTE : cpu_pkg::MSB_WORD;
    mask     = bw ? cpu_pkg::BYTE_MASK : cpu_pkg::WORD_MASK;
    opS      = srcVal_reg & mask;
    opD      = (ad ? dstVal_reg : rf_reg[dReg]) & mask;
    sub      = dop == cpu_pkg::OP_SUBC || dop == cpu_pkg::OP_SUB || dop == cpu_pkg::OP_CMP;
    addend   = sub ? (~opS & mask) : opS;
    cin      = (dop == cpu_pkg::OP_ADDC || dop == cpu_pkg::OP_SUBC) ? sr[cpu_pkg::SR_C] : sub;
    sum      = {1'b0, opD} + {1'b0, addend} + {16'h0000, cin};
    aluRes   = sum[15:0] & mask;
    aluC     = bw ? sum[8] : sum[16];
    aluV     = (opD[msb] == addend[msb]) && (aluRes[msb] != opD[msb]);
    aluFlags = 1'b1;
    if (isSingle) begin
      aluC = opS[0];
      aluV = 1'b0;
      case (sop)
        cpu_pkg::OP_RRC:  aluRes = ((opS >> 1) | ({15'h0000, sr[cpu_pkg::SR_C]} << msb)) & mask;
        cpu_pkg::OP_RRA:  aluRes = ((opS >> 1) | ({15'h0000, opS[msb]} << msb)) & mask;
        cpu_pkg::OP_SXT: begin
          aluRes = {{8{opS[7]}}, opS[7:0]};
          aluC   = |opS[7:0];
        end
        cpu_pkg::OP_SWPB: begin
          aluRes   = {opS[7:0], opS[15:8]};
          aluFlags = 1'b0;
        end
        default: begin
          aluRes   = opS;
          aluFlags = 1'b0;
        end
      endcase
    end else begin
      // decimal add is carried out as a binary add
      case (dop)
        cpu_pkg::OP_MOV, cpu_pkg::OP_BIC, cpu_pkg::OP_BIS: begin
          aluFlags = 1'b0;
          aluRes   = (dop == cpu_pkg::OP_MOV) ? opS :
                     (dop == cpu_pkg::OP_BIC) ? (opD & ~opS) : (opD | opS);
        end
        cpu_pkg::OP_BIT, cpu_pkg::OP_AND, cpu_pkg::OP_XOR: begin
          aluRes = (dop == cpu_pkg::OP_XOR) ? (opD ^ opS) : (opD & opS);
          aluC   = |aluRes;
          aluV   = (dop == cpu_pkg::OP_XOR) && opD[msb] && opS[msb];
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    rf_next = rf_reg;
    {ir_next, srcVal_next, dstVal_next} = {ir_reg, srcVal_reg, dstVal_reg};
    {srcAddr_next, dstAddr_next} = {srcAddr_reg, dstAddr_reg};
    {busAddr_next, busWrData_next, busByte_next} = {busAddr, busWrData, busByte};
    busRd_next  = busRd;
    busWr_next  = busWr;
    irqAck_next = 1'b0;
    if (busDone) begin
      busRd_next = 1'b0;
      busWr_next = 1'b0;
    end
    // every access to memory or peripheral goes over the one bus [RULE_08]
    case (state_reg)
      cpu_pkg::S_BOOT, cpu_pkg::S_IRQVEC: begin
        if (busIdle) begin
          busRd_next   = 1'b1;
          busByte_next = 1'b0;
          busAddr_next = (state_reg == cpu_pkg::S_BOOT) ? cpu_pkg::RESET_VEC : irqVecAddr;
        end else if (busDone) begin
          rf_next[cpu_pkg::R_PC] = busRdData;
          irqAck_next = state_reg == cpu_pkg::S_IRQVEC;
          state_next  = cpu_pkg::S_FETCH;
        end
      end
      cpu_pkg::S_FETCH, cpu_pkg::S_SLEEP: begin
        if (busIdle && irqReq && sr[cpu_pkg::SR_GIE]) begin
          state_next = cpu_pkg::S_IRQPC;  // [RULE_10]
        end else if (busIdle && sr[cpu_pkg::SR_CPUOFF]) begin
          state_next = cpu_pkg::S_SLEEP;  // [RULE_09]
        end else if (busIdle) begin
          busRd_next   = 1'b1;
          busByte_next = 1'b0;
          busAddr_next = rf_reg[cpu_pkg::R_PC];
          state_next   = cpu_pkg::S_FETCH;
        end else if (busDone) begin
          ir_next = busRdData;
          rf_next[cpu_pkg::R_PC] = rf_reg[cpu_pkg::R_PC] + cpu_pkg::STEP_WORD;
          state_next = cpu_pkg::S_DECODE;
        end
      end
      cpu_pkg::S_DECODE: begin
        state_next = isSingle || !ad ? cpu_pkg::S_EXEC : cpu_pkg::S_DSTEXT;
        if (isJump) begin
          if (jumpTaken(ir_reg[12:10], sr))
            rf_next[cpu_pkg::R_PC] = rf_reg[cpu_pkg::R_PC] + jumpOff;  // [RULE_07]
          state_next = cpu_pkg::S_FETCH;
        end else if ((!isSingle && dop < cpu_pkg::OP_MOV) || (isSingle && sop > cpu_pkg::OP_RETI))
          state_next = cpu_pkg::S_FETCH;
        else if (isSingle && sop == cpu_pkg::OP_RETI)
          state_next = cpu_pkg::S_POPSR;
        else if (cgHit)
          srcVal_next = cgValue(sReg, as);
        else if (as == cpu_pkg::AM_REG)
          srcVal_next = rf_reg[sReg];
        else if (srcExt)
          state_next = cpu_pkg::S_SRCEXT;  // [RULE_03]
        else begin
          srcAddr_next = rf_reg[sReg];
          state_next   = cpu_pkg::S_SRCRD;
        end
      end
      cpu_pkg::S_SRCEXT, cpu_pkg::S_DSTEXT: begin
        if (busIdle) begin
          busRd_next   = 1'b1;
          busByte_next = 1'b0;
          busAddr_next = rf_reg[cpu_pkg::R_PC];
        end else if (busDone) begin
          rf_next[cpu_pkg::R_PC] = rf_reg[cpu_pkg::R_PC] + cpu_pkg::STEP_WORD;
          if (state_reg == cpu_pkg::S_DSTEXT) begin
            dstAddr_next = busRdData + extBase(dReg, rf_reg[dReg]);  // [RULE_03]
            state_next = (dop == cpu_pkg::OP_MOV) ? cpu_pkg::S_EXEC : cpu_pkg::S_DSTRD;
          end else if (as == cpu_pkg::AM_INC) begin
            srcVal_next = busRdData;
            state_next  = isSingle || !ad ? cpu_pkg::S_EXEC : cpu_pkg::S_DSTEXT;
          end else begin
            srcAddr_next = busRdData + extBase(sReg, rf_reg[sReg]);
            state_next   = cpu_pkg::S_SRCRD;
          end
        end
      end
      cpu_pkg::S_SRCRD, cpu_pkg::S_DSTRD: begin
        if (busIdle) begin
          busRd_next   = 1'b1;
          busByte_next = bw;
          busAddr_next = (state_reg == cpu_pkg::S_SRCRD) ? srcAddr_reg : dstAddr_reg;
        end else if (busDone && state_reg == cpu_pkg::S_DSTRD) begin
          dstVal_next = busRdData;
          state_next  = cpu_pkg::S_EXEC;
        end else if (busDone) begin
          srcVal_next = busRdData;
          if (as == cpu_pkg::AM_INC) rf_next[sReg] = rf_reg[sReg] + incStep;
          state_next = isSingle || !ad ? cpu_pkg::S_EXEC : cpu_pkg::S_DSTEXT;
        end
      end
      cpu_pkg::S_EXEC: begin
        state_next = cpu_pkg::S_FETCH;
        if (aluFlags) begin
          rf_next[cpu_pkg::R_SR][cpu_pkg::SR_C] = aluC;
          rf_next[cpu_pkg::R_SR][cpu_pkg::SR_Z] = aluRes == cpu_pkg::ZERO16;
          rf_next[cpu_pkg::R_SR][cpu_pkg::SR_N] = aluRes[msb];
          rf_next[cpu_pkg::R_SR][cpu_pkg::SR_V] = aluV;
        end
        dstAddr_next = isSingle ? srcAddr_reg : dstAddr_reg;
        srcVal_next  = aluRes;
        if (isStack) begin
          rf_next[cpu_pkg::R_SP] = rf_reg[cpu_pkg::R_SP] - cpu_pkg::STEP_WORD;
          dstAddr_next = rf_reg[cpu_pkg::R_SP] - cpu_pkg::STEP_WORD;
          state_next   = cpu_pkg::S_WRBACK;
          if (sop == cpu_pkg::OP_CALL) begin
            srcVal_next = rf_reg[cpu_pkg::R_PC];  // [RULE_06]
            rf_next[cpu_pkg::R_PC] = srcVal_reg;
          end
        end else if (!isSingle && (dop == cpu_pkg::OP_CMP || dop == cpu_pkg::OP_BIT))
          state_next = cpu_pkg::S_FETCH;
        else if (ad || (isSingle && as != cpu_pkg::AM_REG))
          state_next = cpu_pkg::S_WRBACK;  // [RULE_05]
        else if ((isSingle ? sReg : dReg) != cpu_pkg::R_CG)
          rf_next[isSingle ? sReg : dReg] = aluRes;  // [RULE_02] [RULE_05]
      end
      cpu_pkg::S_WRBACK, cpu_pkg::S_IRQPC, cpu_pkg::S_IRQSR: begin
        if (busIdle) begin
          busWr_next     = 1'b1;
          busByte_next   = bw && !isStack && state_reg == cpu_pkg::S_WRBACK;
          busAddr_next   = (state_reg == cpu_pkg::S_WRBACK) ? dstAddr_reg :
                           rf_reg[cpu_pkg::R_SP] - cpu_pkg::STEP_WORD;
          busWrData_next = (state_reg == cpu_pkg::S_WRBACK) ? srcVal_reg :
                           (state_reg == cpu_pkg::S_IRQPC) ? rf_reg[cpu_pkg::R_PC] : sr;
        end else if (busDone && state_reg == cpu_pkg::S_WRBACK)
          state_next = cpu_pkg::S_FETCH;
        else if (busDone) begin
          rf_next[cpu_pkg::R_SP] = busAddr;
          state_next = (state_reg == cpu_pkg::S_IRQPC) ? cpu_pkg::S_IRQSR : cpu_pkg::S_IRQVEC;
          if (state_reg == cpu_pkg::S_IRQSR) begin
            rf_next[cpu_pkg::R_SR][cpu_pkg::SR_GIE]    = 1'b0;  // [RULE_16]
            rf_next[cpu_pkg::R_SR][cpu_pkg::SR_CPUOFF] = 1'b0;
            rf_next[cpu_pkg::R_SR][cpu_pkg::SR_OSCOFF] = 1'b0;
            rf_next[cpu_pkg::R_SR][cpu_pkg::SR_SCG0]   = 1'b0;
            rf_next[cpu_pkg::R_SR][cpu_pkg::SR_SCG1]   = 1'b0;
          end
        end
      end
      default: begin  // pop status, then program counter
        if (busIdle) begin
          busRd_next   = 1'b1;
          busByte_next = 1'b0;
          busAddr_next = rf_reg[cpu_pkg::R_SP];
        end else if (busDone) begin
          rf_next[cpu_pkg::R_SP] = rf_reg[cpu_pkg::R_SP] + cpu_pkg::STEP_WORD;
          rf_next[state_reg == cpu_pkg::S_POPSR ? cpu_pkg::R_SR : cpu_pkg::R_PC] = busRdData;
          state_next = (state_reg == cpu_pkg::S_POPSR) ? cpu_pkg::S_POPPC : cpu_pkg::S_FETCH;
        end  // [RULE_10] [RULE_16]
      end
    endcase
    rf_next[cpu_pkg::R_CG] = cpu_pkg::ZERO16;
  end

  // clock gating from the status register mode bits
  always_comb begin
    mainClkEn_next      = !sr[cpu_pkg::SR_CPUOFF];  // [RULE_11]
    subsystemClkEn_next = !sr[cpu_pkg::SR_SCG1];  // [RULE_13] [RULE_14]
    auxClkEn_next       = !sr[cpu_pkg::SR_OSCOFF];  // [RULE_15]
    xtalEn_next         = !sr[cpu_pkg::SR_OSCOFF];  // [RULE_15]
    dcGenEn_next        = !(sr[cpu_pkg::SR_CPUOFF] && sr[cpu_pkg::SR_SCG0] &&
                            (sr[cpu_pkg::SR_SCG1] || !oscInUseActive));  // [RULE_12] [RULE_14]
    if (!sr[cpu_pkg::SR_CPUOFF])     powerMode_next = cpu_pkg::MODE_ACTIVE_OPERATING;
    else if (sr[cpu_pkg::SR_OSCOFF]) powerMode_next = cpu_pkg::MODE_LOW_POWER_FOUR;
    else if (sr[cpu_pkg::SR_SCG1])
      powerMode_next = sr[cpu_pkg::SR_SCG0] ? cpu_pkg::MODE_LOW_POWER_THREE :
                                              cpu_pkg::MODE_LOW_POWER_TWO;
    else powerMode_next = sr[cpu_pkg::SR_SCG0] ? cpu_pkg::MODE_LOW_POWER_ONE :
                                                 cpu_pkg::MODE_LOW_POWER_ZERO;  // [RULE_09]
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= cpu_pkg::S_BOOT;
      for (int i = 0; i < 16; i++) rf_reg[i] <= cpu_pkg::ZERO16;
      {ir_reg, srcVal_reg, dstVal_reg, srcAddr_reg, dstAddr_reg} <= '0;
      {busAddr, busWrData, busRd, busWr, busByte, irqAck} <= '0;
      {mainClkEn, subsystemClkEn, auxClkEn, dcGenEn, xtalEn} <= '1;
      powerMode <= cpu_pkg::MODE_ACTIVE_OPERATING;
    end else if (clkEn) begin
      state_reg <= state_next;
      rf_reg    <= rf_next;
      {ir_reg, srcVal_reg, dstVal_reg} <= {ir_next, srcVal_next, dstVal_next};
      {srcAddr_reg, dstAddr_reg} <= {srcAddr_next, dstAddr_next};
      {busAddr, busWrData, busByte} <= {busAddr_next, busWrData_next, busByte_next};
      {busRd, busWr, irqAck} <= {busRd_next, busWr_next, irqAck_next};
      {mainClkEn, subsystemClkEn, auxClkEn} <= {mainClkEn_next, subsystemClkEn_next, auxClkEn_next};
      {dcGenEn, xtalEn} <= {dcGenEn_next, xtalEn_next};
      powerMode <= powerMode_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wake;
    clkEn && state_reg == cpu_pkg::S_SLEEP && irqReq && sr[cpu_pkg::SR_GIE];
  endsequence
  sequence s_pushSr;
    clkEn && state_reg == cpu_pkg::S_IRQSR && busDone;
  endsequence
  property p_cgConst; rf_reg[cpu_pkg::R_CG] == cpu_pkg::ZERO16; endproperty
  property p_regReg;
    clkEn && state_reg == cpu_pkg::S_EXEC && !isSingle && !ad && dop == cpu_pkg::OP_ADD
      |=> state_reg == cpu_pkg::S_FETCH;
  endproperty
  property p_jne;
    clkEn && state_reg == cpu_pkg::S_DECODE && isJump && ir_reg[12:10] == cpu_pkg::JC_NE
      && sr[cpu_pkg::SR_Z] |=> rf_reg[cpu_pkg::R_PC] == $past(rf_reg[cpu_pkg::R_PC]);
  endproperty
  property p_call;
    clkEn && state_reg == cpu_pkg::S_EXEC && isSingle && sop == cpu_pkg::OP_CALL
      |=> rf_reg[cpu_pkg::R_PC] == $past(srcVal_reg) && srcVal_reg == $past(rf_reg[cpu_pkg::R_PC]);
  endproperty
  property p_busHold;
    clkEn && busRd && !busAck |=> busRd && $stable(busAddr);
  endproperty
  property p_wake; s_wake |=> state_reg == cpu_pkg::S_IRQPC; endproperty
  property p_entryClr;
    s_pushSr |=> !sr[cpu_pkg::SR_CPUOFF] && !sr[cpu_pkg::SR_GIE] ##[1:200] irqAck;
  endproperty
  property p_mode0;
    clkEn && sr[cpu_pkg::SR_CPUOFF] && !sr[cpu_pkg::SR_SCG1] && !sr[cpu_pkg::SR_OSCOFF]
      |=> !mainClkEn && subsystemClkEn && auxClkEn;
  endproperty
  property p_mode3;
    clkEn && sr[cpu_pkg::SR_CPUOFF] && sr[cpu_pkg::SR_SCG1] && sr[cpu_pkg::SR_SCG0]
      |=> !subsystemClkEn && !dcGenEn;
  endproperty
  property p_mode4;
    clkEn && sr[cpu_pkg::SR_CPUOFF] && sr[cpu_pkg::SR_OSCOFF]
      |=> !auxClkEn && !xtalEn && powerMode == cpu_pkg::MODE_LOW_POWER_FOUR;
  endproperty
  a_cgConst: assert property (p_cgConst) else $error("constant register changed");  // [RULE_01]
  a_regReg: assert property (p_regReg) else $error("register op took extra cycle");  // [RULE_02]
  a_jne: assert property (p_jne) else $error("jump taken with zero flag set");  // [RULE_07]
  a_call: assert property (p_call) else $error("call did not load pc");  // [RULE_06]
  a_busHold: assert property (p_busHold) else $error("bus request dropped");  // [RULE_08]
  a_wake: assert property (p_wake) else $error("interrupt did not wake core");  // [RULE_10]
  a_entryClr: assert property (p_entryClr) else $error("mode bits not cleared");  // [RULE_16]
  a_mode0: assert property (p_mode0) else $error("mode zero gating wrong");  // [RULE_11]
  a_mode3: assert property (p_mode3) else $error("mode three gating wrong");  // [RULE_14]
  a_mode4: assert property (p_mode4) else $error("mode four gating wrong");  // [RULE_15]
endmodule  // risc_cpu_core

// ==== tb/bus_mem_model.sv ====
`timescale 1ns/1ns
module bus_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        busRd,
  input  wire logic        busWr,
  input  wire logic [15:0] busAddr,
  input  wire logic [15:0] busWrData,
  input  wire logic        busByte,
  input  wire logic [1:0]  waitCycles,
  output logic             busAck,
  output logic      [15:0] busRdData
);
  logic [15:0] mem [0:255];
  logic [15:0] lastData;
  logic [1:0]  waitCnt;
  initial begin
    busAck = 1'b0;
    waitCnt = 2'h0;
    lastData = 16'h0000;
  end
  // idle data lines show the inverse of the last word
  assign busRdData = busAck ? lastData : ~lastData;
  always @(posedge sys_clk) begin
    busAck <= 1'b0;
    if ((busRd || busWr) && !busAck) begin
      if (waitCnt == waitCycles) begin
        busAck <= 1'b1;
        waitCnt <= 2'h0;
        lastData <= mem[busAddr[8:1]];
        // byte stores land in the half picked by address bit 0
        if (busWr && busByte && busAddr[0]) mem[busAddr[8:1]][15:8] <= busWrData[7:0];
        else if (busWr && busByte) mem[busAddr[8:1]][7:0] <= busWrData[7:0];
        else if (busWr) mem[busAddr[8:1]] <= busWrData;
      end else waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule // bus_mem_model

// ==== tb/risc_cpu_core_power_modes_tb.sv ====
`timescale 1ns/1ns
module risc_cpu_core_power_modes_tb;
  logic sys_clk = 1'b0, sys_rst = 1'b1, irqReq = 1'b0, busAck, busRd, busWr, irqAck;
  logic mainClkEn, subsystemClkEn, auxClkEn, dcGenEn, xtalEn, busByte, oscInUseActive = 1'b0;
  logic [15:0] busRdData, busAddr, busWrData;
  logic [1:0]  waitCycles = 2'h0;
  cpu_pkg::power_mode_e powerMode;
  int failures = 0, checks = 0;
  logic [15:0] prog [0:12] = '{16'h4031, 16'h01f0, 16'h4034, 16'h0005, 16'h5405, 16'h9035,
    16'h0005, 16'h2001, 16'h5405, 16'h4582, 16'h0180, 16'h4032, 16'h0000};
  logic [15:0] bitsTab [0:4] = '{16'h0018, 16'h0058, 16'h0098, 16'h00d8, 16'h00f8};
  logic [4:0]  expTab [0:4] = '{5'h0f, 5'h0d, 5'h07, 5'h05, 5'h00};
  // handler: call routine, return from interrupt; routine: word store, byte store, return
  logic [15:0] hnd [0:7] = '{16'h12b0, 16'h0146, 16'h1300, 16'h4482, 16'h0184, 16'h44c2,
    16'h0186, 16'h4130};
  always #5 sys_clk = ~sys_clk;
  risc_cpu_core u_risc_cpu_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1),
    .busRdData(busRdData), .busAck(busAck), .irqReq(irqReq), .irqVecAddr(16'h01fc),
    .oscInUseActive(oscInUseActive), .busAddr(busAddr), .busWrData(busWrData),
    .busRd(busRd), .busWr(busWr), .busByte(busByte), .irqAck(irqAck), .mainClkEn(mainClkEn),
    .subsystemClkEn(subsystemClkEn), .auxClkEn(auxClkEn), .dcGenEn(dcGenEn),
    .xtalEn(xtalEn), .powerMode(powerMode));
  bus_mem_model u_bus_mem_model (.sys_clk(sys_clk), .busRd(busRd), .busWr(busWr),
    .busAddr(busAddr), .busWrData(busWrData), .busByte(busByte), .waitCycles(waitCycles),
    .busAck(busAck),
    .busRdData(busRdData));
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_mode(input cpu_pkg::power_mode_e m);
    int n;
    n = 0;
    while (powerMode !== m && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  // boot, add, compare, skip-free jump, then sleep in mode m
  task automatic run_mode(input int m);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    waitCycles <= m[1:0];
    for (int i = 0; i < 13; i++) u_bus_mem_model.mem[8'h80 + i] = prog[i];
    u_bus_mem_model.mem[8'h8c] = bitsTab[m];
    u_bus_mem_model.mem[8'hff] = 16'h0100;
    u_bus_mem_model.mem[8'hfe] = 16'h0140;
    for (int i = 0; i < 8; i++) u_bus_mem_model.mem[8'ha0 + i] = hnd[i];
    u_bus_mem_model.mem[8'hc3] = 16'hff00;
    u_bus_mem_model.mem[8'hc0] = 16'h0000;
    u_bus_mem_model.mem[8'hc2] = 16'h0000;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_mode(cpu_pkg::power_mode_e'(m + 1));
    repeat (2) @(posedge sys_clk);
    #1;
    check("mode", 16'(powerMode), 16'(m + 1));
    check("sum", u_bus_mem_model.mem[8'hc0], 16'h000a);
    check("clocks", 16'({mainClkEn, subsystemClkEn, auxClkEn, dcGenEn, xtalEn}),
      16'(expTab[m]));
    // oscillator in use keeps the dc generator on in mode one only
    @(posedge sys_clk);
    oscInUseActive <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("dcGenInUse", 16'(dcGenEn), 16'(expTab[m][1] || m == 1));
    @(posedge sys_clk);
    oscInUseActive <= 1'b0;
    $display("test mode %0d ended", m);
  endtask
  // wake from mode zero, run handler, return to sleep
  task automatic irq_wake;
    @(posedge sys_clk);
    irqReq <= 1'b1;
    for (int n = 0; n < 300 && irqAck !== 1'b1; n++) @(negedge sys_clk);
    check("ack", 16'(irqAck), 16'h0001);
    @(posedge sys_clk);
    irqReq <= 1'b0;
    wait_mode(cpu_pkg::MODE_LOW_POWER_ZERO);
    check("back", 16'(powerMode), 16'(cpu_pkg::MODE_LOW_POWER_ZERO));
    check("handler", u_bus_mem_model.mem[8'hc2], 16'h0005);
    check("callRet", u_bus_mem_model.mem[8'hf5], 16'h0144);
    check("byteStore", u_bus_mem_model.mem[8'hc3], 16'hff05);
    check("savedPc", u_bus_mem_model.mem[8'hf7], 16'h011a);
    check("savedSr", u_bus_mem_model.mem[8'hf6] & 16'h00f8, 16'h0018);
    $display("test wake ended");
  endtask
  initial begin
    run_mode(0);
    irq_wake();
    for (int m = 1; m < 5; m++) run_mode(m);
    stop_test();
  end
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule // risc_cpu_core_power_modes_tb
